// *** sts_sequencer.sv ***
// sweep trigger sequencer with its AHB-Lite register slave
//
// Register access over AHB-Lite and the address map were decided locally.
`default_nettype none
// How it works
// (RULE1) idle holds until a sweep is initiated, then goes to wait-for-trigger.
// (RULE2) continuous rearm starts a new sweep each time one ends.
// (RULE3) without rearm, each single initiate command gives exactly one sweep.
// (RULE4) clearing rearm mid sweep lets it finish, then it stops in idle.
// (RULE5) waiting looks only at the selected start source until it is true.
// (RULE6) the always-true source never makes the sequencer wait.
// (RULE7) external source: a rising edge on the jack is a trigger.
// (RULE8) bus source: group execute trigger or bus trigger command fires.
// (RULE9) a true start trigger moves straight into sweeping.
// (RULE10) stepped and list sweeps each have their own point-advance source.
// (RULE11) first point comes at sweep start, each point trigger advances.
// (RULE12) a point trigger on the last point ends the sweep.
// (RULE13) analog sweeps ignore point triggers and end on source done.
// (RULE14) abort returns to idle at once from any state.
// (RULE15) abort keeps configuration; only reset or preset restores defaults.
// (RULE16) operation complete pulses only when a sweep re-enters idle.
// (RULE17) always_true_source override works once in wait; elsewhere it flags an error.
// (RULE18) one source is selected at a time, others are ignored.
// (RULE19) programmable delay from settling to trigger out, reset value zero.
// (RULE20) pending flag sets on leaving idle, clears on return to idle.
// (RULE21) external input is synchronised, one pulse per rising edge.
module sts_sequencer (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // trigger inputs
  input wire logic extTrigIn,
  input wire logic busGet,
  // sweep hardware handshake
  input wire logic sourceSettled,
  input wire logic analogDone,
  // sweep outputs
  output logic [15:0] pointIndex,
  output logic sweepActive,
  output logic trigOut,
  output logic opComplete,
  output logic opPending,
  output logic cmdError
);

  // ****************************************
  // declarations
  // ****************************************
  sts_pkg::sts_ctrl_t ctrl_r;
  logic [15:0] points_r;
  logic [15:0] delay_r;
  sts_pkg::sts_state_t state_r;
  sts_pkg::sts_state_t state_nxt;
  logic [15:0] pointIdx_r;
  logic [15:0] pointIdx_nxt;
  logic doneFlag_r;
  logic errFlag_r;
  logic wrPend_r;
  logic [7:0] wrAddr_r;
  logic addrValid;
  logic wrCmd;
  logic [5:0] cmd;
  logic extPulse;
  logic busTrig;
  logic startTrue;
  logic pointTrue;
  logic [1:0] pointSel;
  logic lastPoint;
  logic sweepEnd;
  logic enterIdle;
  logic leaveIdle;
  logic [15:0] dlyCnt_r;
  logic dlyRun_r;
  logic [31:0] statusWord;
  logic [31:0] rdMux;

  // ****************************************
  // external trigger edge
  // ****************************************
  sts_edge_sync uEdge (
    .mclk(mclk),
    .rst(rst),
    .pinIn(extTrigIn),
    .risePulse(extPulse)
  );

  // ****************************************
  // bus address phase
  // ****************************************
  // zero wait state slave: every access completes in one data phase
  assign addrValid = hsel & hready & htrans[1];

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
    end else begin
      wrPend_r <= addrValid & hwrite;
      if (addrValid) begin
        wrAddr_r <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[sts_pkg::ST_STATE_LSB +: 3] = state_r;
    statusWord[sts_pkg::ST_PENDING] = opPending;
    statusWord[sts_pkg::ST_DONE] = doneFlag_r;
    statusWord[sts_pkg::ST_ERROR] = errFlag_r;
    statusWord[sts_pkg::ST_IDX_LSB +: 16] = pointIdx_r;
  end

  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (haddr[7:0])
      sts_pkg::ADDR_CTRL: rdMux = {23'h00_0000, ctrl_r};
      sts_pkg::ADDR_POINTS: rdMux = {16'h0000, points_r};
      sts_pkg::ADDR_DELAY: rdMux = {16'h0000, delay_r};
      sts_pkg::ADDR_STATUS: rdMux = statusWord;
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // read data is latched at the address phase so it stands all data phase
  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (addrValid & ~hwrite) begin
      hrdata <= rdMux;
    end
  end

  // ****************************************
  // write path
  // ****************************************
  assign wrCmd = wrPend_r & (wrAddr_r == sts_pkg::ADDR_CMD);
  assign cmd = wrCmd ? hwdata[5:0] : 6'h00;

  // abort touches none of these; preset and reset do
  always_ff @(posedge mclk) begin
    if (rst | cmd[sts_pkg::CMD_PRESET]) begin
      ctrl_r <= sts_pkg::CTRL_RST; // (RULE15)
      points_r <= sts_pkg::POINTS_RST;
      delay_r <= sts_pkg::DELAY_RST; // (RULE19)
    end else if (wrPend_r) begin
      if (wrAddr_r == sts_pkg::ADDR_CTRL) begin
        ctrl_r <= sts_pkg::sts_ctrl_t'(hwdata[sts_pkg::CTRL_W-1:0]);
      end
      if (wrAddr_r == sts_pkg::ADDR_POINTS) begin
        points_r <= hwdata[15:0];
      end
      if (wrAddr_r == sts_pkg::ADDR_DELAY) begin
        delay_r <= hwdata[15:0];
      end
    end
  end

  // ****************************************
  // trigger source selection
  // ****************************************
  assign busTrig = busGet | cmd[sts_pkg::CMD_BUSTRIG]; // (RULE8)

  always_comb begin
    startTrue = 1'b0;
    unique case (ctrl_r.startTriggerSelect) // (RULE5) (RULE18)
      sts_pkg::SRC_ALWAYS: startTrue = 1'b1; // (RULE6)
      sts_pkg::SRC_EXT: startTrue = extPulse; // (RULE7)
      sts_pkg::SRC_BUS: startTrue = busTrig; // (RULE8)
      default: startTrue = 1'b0;
    endcase
  end

  // each stepped kind keeps its own advance source
  assign pointSel = (ctrl_r.sweepType == sts_pkg::SWP_LIST) ?
                    ctrl_r.listPointSel : ctrl_r.stepPointSel; // (RULE10)

  always_comb begin
    pointTrue = 1'b0;
    unique case (pointSel) // (RULE18)
      sts_pkg::SRC_ALWAYS: pointTrue = 1'b1;
      sts_pkg::SRC_EXT: pointTrue = extPulse;
      sts_pkg::SRC_BUS: pointTrue = busTrig;
      default: pointTrue = 1'b0;
    endcase
  end

  // ****************************************
  // sequencer state machine
  // ****************************************
  // a points value of zero is treated as a single point sweep
  assign lastPoint = (pointIdx_r + 16'h0001 >= points_r);

  always_comb begin
    sweepEnd = 1'b0;
    if (state_r == sts_pkg::ST_SWEEP) begin
      if (ctrl_r.sweepType == sts_pkg::SWP_ANALOG) begin
        sweepEnd = analogDone; // (RULE13)
      end else begin
        sweepEnd = pointTrue & lastPoint; // (RULE12)
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    pointIdx_nxt = pointIdx_r;
    unique case (state_r)
      sts_pkg::ST_IDLE: begin
        if (cmd[sts_pkg::CMD_INIT] | ctrl_r.continuousRearm) begin
          state_nxt = sts_pkg::ST_WAIT; // (RULE1) (RULE3)
        end
      end
      sts_pkg::ST_WAIT: begin
        if (startTrue | cmd[sts_pkg::CMD_IMMOVR]) begin
          state_nxt = sts_pkg::ST_SWEEP; // (RULE9) (RULE17)
          pointIdx_nxt = 16'h0000; // (RULE11)
        end
      end
      sts_pkg::ST_SWEEP: begin
        if (sweepEnd) begin
          // within a sweep rearm is looked at only here, so a cleared bit ends cleanly
          state_nxt = ctrl_r.continuousRearm ?
                      sts_pkg::ST_WAIT : sts_pkg::ST_IDLE; // (RULE2) (RULE4)
        end else if ((ctrl_r.sweepType != sts_pkg::SWP_ANALOG) & pointTrue) begin
          pointIdx_nxt = pointIdx_r + 16'h0001; // (RULE11)
        end
      end
    endcase
    if (cmd[sts_pkg::CMD_ABORT]) begin
      state_nxt = sts_pkg::ST_IDLE; // (RULE14)
      pointIdx_nxt = 16'h0000;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= sts_pkg::ST_IDLE;
      pointIdx_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      pointIdx_r <= pointIdx_nxt;
    end
  end

  assign leaveIdle = (state_r == sts_pkg::ST_IDLE) & (state_nxt != sts_pkg::ST_IDLE);
  assign enterIdle = (state_r != sts_pkg::ST_IDLE) & (state_nxt == sts_pkg::ST_IDLE);

  // ****************************************
  // completion and pending flags
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      opPending <= 1'b0;
    end else if (leaveIdle) begin
      opPending <= 1'b1; // (RULE20)
    end else if (enterIdle) begin
      opPending <= 1'b0; // (RULE20)
    end
  end

  // abort reaches idle too, but is not a completed sweep
  always_ff @(posedge mclk) begin
    if (rst) begin
      opComplete <= 1'b0;
    end else begin
      opComplete <= enterIdle & sweepEnd & ~cmd[sts_pkg::CMD_ABORT]; // (RULE16)
    end
  end

  // sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      doneFlag_r <= 1'b0;
    end else if (enterIdle & sweepEnd & ~cmd[sts_pkg::CMD_ABORT]) begin
      doneFlag_r <= 1'b1; // (RULE16)
    end else if (cmd[sts_pkg::CMD_CLRFLAGS]) begin
      doneFlag_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      errFlag_r <= 1'b0;
    end else if (cmd[sts_pkg::CMD_IMMOVR] & (state_r != sts_pkg::ST_WAIT)) begin
      errFlag_r <= 1'b1; // (RULE17)
    end else if (cmd[sts_pkg::CMD_CLRFLAGS]) begin
      errFlag_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cmdError <= 1'b0;
    end else begin
      cmdError <= errFlag_r;
    end
  end

  // ****************************************
  // settle to trigger out delay
  // ****************************************
  // a new settle restarts the count; only the latest point is announced
  always_ff @(posedge mclk) begin
    if (rst | cmd[sts_pkg::CMD_ABORT]) begin
      dlyRun_r <= 1'b0;
      dlyCnt_r <= 16'h0000;
    end else if (sourceSettled & (state_r == sts_pkg::ST_SWEEP)) begin
      dlyRun_r <= 1'b1;
      dlyCnt_r <= delay_r; // (RULE19)
    end else if (dlyRun_r & (dlyCnt_r != 16'h0000)) begin
      dlyCnt_r <= dlyCnt_r - 16'h0001;
    end else begin
      dlyRun_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      trigOut <= 1'b0;
    end else begin
      trigOut <= dlyRun_r & (dlyCnt_r == 16'h0000) &
                 ~cmd[sts_pkg::CMD_ABORT] &
                 ~(sourceSettled & (state_r == sts_pkg::ST_SWEEP)); // (RULE19)
    end
  end

  // ****************************************
  // sweep outputs
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      pointIndex <= 16'h0000;
      sweepActive <= 1'b0;
    end else begin
      pointIndex <= pointIdx_nxt;
      sweepActive <= (state_nxt == sts_pkg::ST_SWEEP);
    end
  end

endmodule
`default_nettype wire

// *** sts_pkg.sv ***
// shared constants, types and register map of the sweep trigger sequencer
`default_nettype none
package sts_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_POINTS = 8'h08;
  localparam logic [7:0] ADDR_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // ****************************************
  // command bits (write one to act)
  // ****************************************
  localparam int CMD_INIT = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_BUSTRIG = 2;
  localparam int CMD_IMMOVR = 3;
  localparam int CMD_CLRFLAGS = 4;
  localparam int CMD_PRESET = 5;

  // ****************************************
  // status field positions
  // ****************************************
  localparam int ST_STATE_LSB = 0;
  localparam int ST_PENDING = 3;
  localparam int ST_DONE = 4;
  localparam int ST_ERROR = 5;
  localparam int ST_IDX_LSB = 16;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    SRC_ALWAYS = 2'h0,
    SRC_EXT = 2'h1,
    SRC_BUS = 2'h2
  } sts_src_t;

  typedef enum logic [1:0] {
    SWP_ANALOG = 2'h0,
    SWP_STEPPED = 2'h1,
    SWP_LIST = 2'h2
  } sts_sweep_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SWEEP = 3'b100
  } sts_state_t;

  // control register image, bit 8 downward
  typedef struct packed {
    logic [1:0] listPointSel;
    logic [1:0] stepPointSel;
    logic [1:0] sweepType;
    logic [1:0] startTriggerSelect;
    logic continuousRearm;
  } sts_ctrl_t;

  localparam int CTRL_W = 9;
  localparam sts_ctrl_t CTRL_RST = '{
    listPointSel: 2'h0,
    stepPointSel: 2'h0,
    sweepType: 2'h0,
    startTriggerSelect: 2'h0,
    continuousRearm: 1'b0
  };
  localparam logic [15:0] POINTS_RST = 16'h0002;
  localparam logic [15:0] DELAY_RST = 16'h0000;

endpackage
`default_nettype wire

// *** sts_edge_sync.sv ***
// synchroniser and rising edge pulse for the external trigger jack
`default_nettype none
module sts_edge_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pin and pulse
  input wire logic pinIn,
  output logic risePulse
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // ****************************************
  // two stage synchroniser, then edge
  // ****************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      risePulse <= 1'b0;
    end else begin
      risePulse <= sync_r & ~prev_r; // (RULE21) (RULE7)
    end
  end
endmodule
`default_nettype wire

// *** sts_sequencer_properties.sv ***
// concurrent checks on the sweep trigger sequencer outputs
`default_nettype none
module sts_sequencer_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // watched outputs
  input wire logic [15:0] pointIndex,
  input wire logic sweepActive,
  input wire logic opComplete,
  input wire logic opPending
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ****************
  // sequences
  // ****************
  sequence s_enter_sweep;
    !sweepActive ##1 sweepActive;
  endsequence
  sequence s_in_sweep;
    sweepActive [*2];
  endsequence
  // ****************
  // properties
  // ****************
  a_idle_after_reset: assert property ($fell(rst) |-> !opPending [*2])
    else $error("pending straight out of reset");
  a_pend_in_sweep: assert property (sweepActive |-> opPending)
    else $error("sweeping without pending flag");
  a_enter_first_point: assert property (s_enter_sweep |->
    opPending && pointIndex == 16'h0000)
    else $error("sweep did not start at the first point");
  a_point_step: assert property (s_in_sweep |->
    pointIndex == $past(pointIndex) || pointIndex == $past(pointIndex) + 16'h0001)
    else $error("point index jumped by more than one");
  a_done_at_end: assert property (opComplete |-> !opPending && $past(sweepActive))
    else $error("complete pulse not at sweep end");
  a_done_pulse: assert property (opComplete |=> !opComplete)
    else $error("complete pulse longer than one cycle");
  a_done_quiet: assert property (opComplete |-> !sweepActive [*2])
    else $error("sweeping right after complete");
  a_pend_fall: assert property ($fell(opPending) |-> !sweepActive)
    else $error("pending cleared while sweeping");
endmodule
`default_nettype wire

// *** sts_host_model.sv ***
// host controller and trigger jack model facing the sequencer
`default_nettype none
module sts_host_model (
  // clock
  input wire logic mclk,
  // ahb-lite master
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // trigger jack and sweep hardware
  output logic extTrigIn,
  output logic busGet,
  output logic sourceSettled,
  output logic analogDone
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {hsel, hwrite, extTrigIn, busGet, sourceSettled, analogDone} = 6'h00;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
  end
  // single word transfer; released write data is inverted so stale data never matches
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    q = hrdata;
    hwdata <= ~d;
  endtask
  // jack level; a trigger is a low-to-high step
  task automatic jack(input logic v);
    @(posedge mclk);
    extTrigIn <= v;
  endtask
  // one-cycle pulse: 0 bus trigger, 1 settled, 2 analog done
  task automatic pulse(input int k);
    @(posedge mclk);
    {analogDone, sourceSettled, busGet} <= 3'(1 << k);
    @(posedge mclk);
    {analogDone, sourceSettled, busGet} <= 3'h0;
  endtask
endmodule
`default_nettype wire

// *** test_sweep_trigger_sequencer.sv ***
// self-checking testbench of the sweep trigger sequencer
`default_nettype none
module test_sweep_trigger_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk;
  logic rst;
  wire logic hsel, hwrite, hready, extTrigIn, busGet, sourceSettled, analogDone;
  wire logic sweepActive, trigOut, opComplete, opPending, cmdError, hresp;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0] htrans;
  wire logic [2:0] hsize;
  wire logic [15:0] pointIndex;
  int n_errors = 0;
  int check_count = 0;
  logic [31:0] rdv;

  sts_sequencer sts_sequencer_i (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .extTrigIn(extTrigIn), .busGet(busGet),
    .sourceSettled(sourceSettled), .analogDone(analogDone), .pointIndex(pointIndex),
    .sweepActive(sweepActive), .trigOut(trigOut), .opComplete(opComplete),
    .opPending(opPending), .cmdError(cmdError));
  sts_host_model sts_host_model_i (.mclk(mclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .extTrigIn(extTrigIn), .busGet(busGet), .sourceSettled(sourceSettled),
    .analogDone(analogDone));

  // ****************
  // helpers
  // ****************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    check({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    sts_host_model_i.xfer(1'b1, a, d, rdv);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    sts_host_model_i.xfer(1'b0, a, 32'h0000_0000, rdv);
    check(rdv & m, e);
    chkb(hresp, 1'b0);
  endtask
  task automatic cmd(input int b);
    wr(sts_pkg::ADDR_CMD, 32'h0000_0001 << b);
  endtask
  task automatic waitact(input logic v);
    for (int i = 0; i < 50 && sweepActive !== v; i++) @(negedge mclk);
    chkb(sweepActive, v);
  endtask
  function automatic logic [31:0] ctrl(input logic [1:0] lp, sp, ty, st, input logic cr);
    return {23'h00_0000, lp, sp, ty, st, cr};
  endfunction
  function automatic logic [31:0] stat(input logic e, dn, p, input logic [2:0] s);
    return {16'h0000, 10'h000, e, dn, p, s};
  endfunction

  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    rd(sts_pkg::ADDR_CTRL, 32'h0000_0000);
    rd(sts_pkg::ADDR_POINTS, 32'h0000_0002);
    rd(sts_pkg::ADDR_DELAY, 32'h0000_0000);
    rd(sts_pkg::ADDR_STATUS, stat(1'b0, 1'b0, 1'b0, 3'h1));
    rd(8'h14, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_stepped;
    wr(sts_pkg::ADDR_CTRL, ctrl(2'h0, 2'h2, 2'h1, 2'h0, 1'b0));
    cmd(sts_pkg::CMD_INIT);
    waitact(1'b1);
    check({16'h0000, pointIndex}, 32'h0000_0000);
    sts_host_model_i.pulse(0);
    @(negedge mclk);
    check({16'h0000, pointIndex}, 32'h0000_0001);
    cmd(sts_pkg::CMD_BUSTRIG);
    @(negedge mclk);
    chkb(opComplete, 1'b1);
    rd(sts_pkg::ADDR_STATUS, stat(1'b0, 1'b1, 1'b0, 3'h1), 32'h0000_FFFF);
    cmd(sts_pkg::CMD_CLRFLAGS);
    $display("stepped test done");
  endtask
  task automatic t_external;
    wr(sts_pkg::ADDR_CTRL, ctrl(2'h0, 2'h0, 2'h0, 2'h1, 1'b0));
    cmd(sts_pkg::CMD_INIT);
    sts_host_model_i.pulse(0);
    repeat (6) @(negedge mclk);
    rd(sts_pkg::ADDR_STATUS, stat(1'b0, 1'b0, 1'b1, 3'h2), 32'h0000_FFFF);
    sts_host_model_i.jack(1'b1);
    waitact(1'b1);
    sts_host_model_i.pulse(0);
    repeat (3) @(negedge mclk);
    check({15'h0000, sweepActive, pointIndex}, 32'h0001_0000);
    sts_host_model_i.jack(1'b0);
    sts_host_model_i.pulse(2);
    @(negedge mclk);
    chkb(opComplete, 1'b1);
    cmd(sts_pkg::CMD_CLRFLAGS);
    $display("external test done");
  endtask
  task automatic t_override;
    wr(sts_pkg::ADDR_CTRL, ctrl(2'h0, 2'h0, 2'h0, 2'h3, 1'b0));
    cmd(sts_pkg::CMD_IMMOVR);
    rd(sts_pkg::ADDR_STATUS, stat(1'b1, 1'b0, 1'b0, 3'h1), 32'h0000_FFFF);
    chkb(cmdError, 1'b1);
    cmd(sts_pkg::CMD_INIT);
    cmd(sts_pkg::CMD_IMMOVR);
    waitact(1'b1);
    cmd(sts_pkg::CMD_ABORT);
    @(negedge mclk);
    check({29'h0000_0000, sweepActive, opPending, opComplete}, 32'h0000_0000);
    rd(sts_pkg::ADDR_CTRL, ctrl(2'h0, 2'h0, 2'h0, 2'h3, 1'b0));
    cmd(sts_pkg::CMD_PRESET);
    rd(sts_pkg::ADDR_CTRL, 32'h0000_0000);
    cmd(sts_pkg::CMD_CLRFLAGS);
    $display("override and abort test done");
  endtask
  task automatic t_rearm;
    int n;
    logic prev;
    n = 0;
    prev = 1'b0;
    wr(sts_pkg::ADDR_CTRL, ctrl(2'h0, 2'h0, 2'h1, 2'h0, 1'b1));
    repeat (40) begin
      @(negedge mclk);
      if (sweepActive === 1'b1 && !prev) n++;
      prev = sweepActive;
    end
    chkb(n > 2, 1'b1);
    wr(sts_pkg::ADDR_CTRL, ctrl(2'h0, 2'h0, 2'h1, 2'h0, 1'b0));
    repeat (10) @(negedge mclk);
    rd(sts_pkg::ADDR_STATUS, stat(1'b0, 1'b1, 1'b0, 3'h1), 32'h0000_FFFF);
    cmd(sts_pkg::CMD_CLRFLAGS);
    $display("rearm test done");
  endtask
  task automatic t_delay;
    int n;
    n = 0;
    wr(sts_pkg::ADDR_DELAY, 32'h0000_0003);
    wr(sts_pkg::ADDR_CTRL, ctrl(2'h0, 2'h2, 2'h1, 2'h2, 1'b0));
    cmd(sts_pkg::CMD_INIT);
    sts_host_model_i.pulse(0);
    waitact(1'b1);
    sts_host_model_i.pulse(1);
    do begin
      @(negedge mclk);
      n++;
    end while (trigOut !== 1'b1 && n < 20);
    check(n, 32'h0000_0005);
    cmd(sts_pkg::CMD_ABORT);
    $display("delay test done");
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    conclude;
  end
  initial begin
    rst = 1'b1;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_stepped;
    t_external;
    t_override;
    t_rearm;
    t_delay;
    conclude;
  end
endmodule

bind sts_sequencer sts_sequencer_properties sts_sequencer_properties_i (.mclk(mclk),
  .rst(rst), .pointIndex(pointIndex), .sweepActive(sweepActive), .opComplete(opComplete),
  .opPending(opPending));
`default_nettype wire
